// ==== rtl/agu_pkg.sv ====
// agu_pkg: constants and types for the data address generation unit
// assumes a 16-bit word-addressed data memory and a decoder on the same clock
`default_nettype none
package agu_pkg;
  localparam int unsigned AW = 16;
  localparam int unsigned NREG = 8;
  localparam int unsigned DISP_W = 7;
  localparam logic [AW-1:0] RST_VAL = 16'h0000;

  // ============================================================
  // addressing groups
  typedef enum logic [1:0] {
    MODE_DIRECT = 2'h0,
    MODE_GROUP_A = 2'h1,
    MODE_GROUP_B = 2'h2,
    MODE_GROUP_C = 2'h3
  } agu_mode_t;

  // ============================================================
  // post-modify selection
  typedef enum logic [3:0] {
    UPD_P3 = 4'h0,
    UPD_P2 = 4'h1,
    UPD_P1 = 4'h2,
    UPD_Z = 4'h3,
    UPD_M1 = 4'h4,
    UPD_M2 = 4'h5,
    UPD_M3 = 4'h6,
    UPD_INC0 = 4'h7,
    UPD_INC1 = 4'h8,
    UPD_BASE = 4'h9
  } agu_upd_t;

  // ============================================================
  // transfer kinds
  typedef enum logic [1:0] {
    OP_SINGLE = 2'h0,
    OP_DUAL = 2'h1,
    OP_ARITH = 2'h2
  } agu_op_t;

  localparam logic [2:0] CIRC_REG_IDX = 3'h7;
endpackage : agu_pkg
`default_nettype wire

// ==== rtl/agu_step.sv ====
// agu_step: post-modify step value for the selected update choice
// assumes the group legality is checked by the caller
`default_nettype none
module agu_step
  import agu_pkg::*;
(
  // selection
  input wire agu_upd_t upd,
  input wire logic [AW-1:0] inc0,
  input wire logic [AW-1:0] inc1,
  // result
  output logic [AW-1:0] step
);
  always_comb begin
    case (upd)
      UPD_P3: step = 16'h0003;
      UPD_P2: step = 16'h0002;
      UPD_P1: step = 16'h0001;
      UPD_M1: step = 16'hffff;
      UPD_M2: step = 16'hfffe;
      UPD_M3: step = 16'hfffd;
      UPD_INC0: step = inc0;
      UPD_INC1: step = inc1;
      default: step = 16'h0000;
    endcase
  end
endmodule : agu_step
`default_nettype wire

// ==== rtl/agu_wrap.sv ====
// agu_wrap: circular wrap of an updated pointer inside [0, modulo]
// assumes the pointer sits inside the range before the step
`default_nettype none
module agu_wrap
  import agu_pkg::*;
(
  // operands
  input wire logic [AW-1:0] ptr,
  input wire logic [AW-1:0] step,
  input wire logic [AW-1:0] modulo,
  // result
  output logic [AW-1:0] next_ptr
);
  logic [AW:0] sum;
  logic [AW:0] span;
  always_comb begin
    sum = {1'b0, ptr} + {1'b0, step};
    span = {1'b0, modulo} + 17'h00001;
    next_ptr = sum[AW-1:0];
    // zero modulo: plain linear update
    if (modulo != 16'h0000) begin
      if (step[AW-1] && (sum[AW] == 1'b0)) begin
        next_ptr = sum[AW-1:0] + span[AW-1:0];
      end else if (!step[AW-1] && (sum > {1'b0, modulo})) begin
        next_ptr = sum[AW-1:0] - span[AW-1:0];
      end
    end
  end
endmodule : agu_wrap
`default_nettype wire

// ==== rtl/agu_core.sv ====
// agu_core: data address generation unit of a 16-bit fixed-point processor
// assumes one processor clock; requests come from the decoder on that clock
`default_nettype none
module agu_core
  import agu_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // request from decoder
  input wire logic REQ_VALID,
  input wire agu_mode_t MODE,
  input wire agu_op_t OP_KIND,
  input wire logic [2:0] PTR_SEL,
  input wire agu_upd_t UPD_SEL,
  input wire logic CIRC_SEL,
  input wire logic [AW-1:0] IMMEDIATE_ADDRESS,
  input wire logic [DISP_W-1:0] SHORT_DISPLACEMENT,
  // register load from the core
  input wire logic LOAD_VALID,
  input wire logic [3:0] LOAD_SEL,
  input wire logic [AW-1:0] LOAD_DATA,
  // to data memory
  output logic ADDR_VALID,
  output logic [AW-1:0] ADDR,
  output logic ADDR_ERROR,
  // pointer readback
  output logic [AW-1:0] CIRCULAR_POINTER_REG
);
  // ============================================================
  // load selectors: 0-7 pointers, then increments, base, offset, modulo
  localparam logic [3:0] LD_INC0 = 4'h8;
  localparam logic [3:0] LD_INC1 = 4'h9;
  localparam logic [3:0] LD_BASE = 4'ha;
  localparam logic [3:0] LD_OFS = 4'hb;
  localparam logic [3:0] LD_MOD = 4'hc;

  typedef struct packed {
    logic [NREG-1:0][AW-1:0] ptr;
    logic [AW-1:0] increment_reg_0;
    logic [AW-1:0] increment_reg_1;
    logic [AW-1:0] base_pointer_reg;
    logic [AW-1:0] circular_offset_reg;
    logic [AW-1:0] modulo_range_reg;
    logic addr_valid;
    logic [AW-1:0] addr;
    logic addr_error;
  } state_t;

  state_t s_q, s_d;

  // ============================================================
  // legality of a request
  function automatic logic legal(input agu_mode_t m, input agu_op_t k,
                                 input logic [2:0] p, input agu_upd_t u,
                                 input logic c);
    logic ok;
    ok = 1'b1;
    case (m)
      MODE_DIRECT: ok = (k == OP_SINGLE);
      MODE_GROUP_A: begin
        ok = (p[2] == 1'b0) && !c &&
             (u == UPD_P1 || u == UPD_Z || u == UPD_M1 || u == UPD_INC0);
      end
      MODE_GROUP_B: begin
        ok = (p >= 3'h4) && (u != UPD_INC0) && (u != UPD_BASE) &&
             (c == (p == CIRC_REG_IDX));
      end
      MODE_GROUP_C: begin
        // group c allows single register transfers only
        ok = (k == OP_SINGLE) && (u != UPD_P3);
      end
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : legal

  logic [AW-1:0] cur;
  logic [AW-1:0] step;
  logic [AW-1:0] wrapped;
  logic circ;
  logic ok;
  logic [AW-1:0] disp_ext;

  assign cur = s_q.ptr[PTR_SEL];
  assign disp_ext = {{(AW-DISP_W){SHORT_DISPLACEMENT[DISP_W-1]}},
                     SHORT_DISPLACEMENT};

  // group b pointer 7 is circular automatically
  assign circ = (MODE == MODE_GROUP_B) ? (PTR_SEL == CIRC_REG_IDX)
              : (MODE == MODE_GROUP_C) ? CIRC_SEL : 1'b0;
  assign ok = legal(MODE, OP_KIND, PTR_SEL, UPD_SEL, CIRC_SEL);

  agu_step u_step (
    .upd(UPD_SEL),
    .inc0(s_q.increment_reg_0),
    .inc1(s_q.increment_reg_1),
    .step(step)
  );

  // modulo zero falls back to linear stepping inside the wrapper
  agu_wrap u_wrap (
    .ptr(cur),
    .step(step),
    .modulo(circ ? s_q.modulo_range_reg : 16'h0000),
    .next_ptr(wrapped)
  );

  // ============================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.addr_valid = 1'b0;
    s_d.addr_error = 1'b0;
    if (LOAD_VALID) begin
      if (LOAD_SEL[3] == 1'b0) begin
        s_d.ptr[LOAD_SEL[2:0]] = LOAD_DATA;
      end else if (LOAD_SEL == LD_INC0) begin
        s_d.increment_reg_0 = LOAD_DATA;
      end else if (LOAD_SEL == LD_INC1) begin
        s_d.increment_reg_1 = LOAD_DATA;
      end else if (LOAD_SEL == LD_BASE) begin
        s_d.base_pointer_reg = LOAD_DATA;
      end else if (LOAD_SEL == LD_OFS) begin
        s_d.circular_offset_reg = LOAD_DATA;
      end else if (LOAD_SEL == LD_MOD) begin
        s_d.modulo_range_reg = LOAD_DATA;
      end
    end
    if (REQ_VALID) begin
      if (!ok) begin
        // illegal combination: flag it, touch no pointer
        s_d.addr_error = 1'b1;
      end else begin
        s_d.addr_valid = 1'b1;
        case (MODE)
          MODE_DIRECT: s_d.addr = IMMEDIATE_ADDRESS;
          default: begin
            if (MODE == MODE_GROUP_C && UPD_SEL == UPD_BASE) begin
              s_d.addr = s_q.base_pointer_reg + disp_ext;
            end else begin
              // pre-update value out, word steps back in
              s_d.addr = circ ? (s_q.circular_offset_reg + cur)
                              : cur;
              s_d.ptr[PTR_SEL] = wrapped;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ADDR_VALID = s_q.addr_valid;
  assign ADDR = s_q.addr;
  assign ADDR_ERROR = s_q.addr_error;
  assign CIRCULAR_POINTER_REG = s_q.ptr[CIRC_REG_IDX];

  // ============================================================
  // assertions
  property p_direct;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && MODE == MODE_DIRECT && OP_KIND == OP_SINGLE && !LOAD_VALID)
      |=> (ADDR_VALID && ADDR == $past(IMMEDIATE_ADDRESS)
           && s_q.ptr == $past(s_q.ptr));
  endproperty
  a_direct: assert property (p_direct) else $error("direct addr wrong");

  property p_group_a_nocirc;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && MODE == MODE_GROUP_A && ok) |=> (ADDR == $past(cur));
  endproperty
  a_group_a_nocirc: assert property (p_group_a_nocirc)
    else $error("group a address not pointer");

  property p_group_a_bad;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && MODE == MODE_GROUP_A && PTR_SEL[2]) |=> ADDR_ERROR;
  endproperty
  a_group_a_bad: assert property (p_group_a_bad)
    else $error("group a high pointer accepted");

  property p_inc_step;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && ok && !circ && MODE != MODE_DIRECT && !LOAD_VALID
     && UPD_SEL == UPD_P1)
      |=> (s_q.ptr[$past(PTR_SEL)] == $past(cur) + 16'h0001);
  endproperty
  a_inc_step: assert property (p_inc_step)
    else $error("word step wrong");

  property p_circ_addr;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && ok && MODE == MODE_GROUP_B && PTR_SEL == CIRC_REG_IDX)
      |=> (ADDR == $past(s_q.circular_offset_reg) + $past(cur));
  endproperty
  a_circ_addr: assert property (p_circ_addr)
    else $error("circular address wrong");

  property p_b_noncirc_err;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && MODE == MODE_GROUP_B && PTR_SEL == CIRC_REG_IDX && !CIRC_SEL)
      |=> ADDR_ERROR;
  endproperty
  a_b_noncirc_err: assert property (p_b_noncirc_err)
    else $error("pointer 7 linear in group b");

  property p_zero_mod;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && ok && circ && s_q.modulo_range_reg == 16'h0000
     && s_q.circular_offset_reg == 16'h0000 && !LOAD_VALID
     && UPD_SEL != UPD_BASE)
      |=> (ADDR == $past(cur)
           && s_q.ptr[$past(PTR_SEL)] == $past(cur) + $past(step));
  endproperty
  a_zero_mod: assert property (p_zero_mod)
    else $error("zero modulo not linear");

  property p_base;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && ok && MODE == MODE_GROUP_C && UPD_SEL == UPD_BASE
     && !LOAD_VALID)
      |=> (ADDR == $past(s_q.base_pointer_reg) + $past(disp_ext)
           && s_q.ptr == $past(s_q.ptr));
  endproperty
  a_base: assert property (p_base) else $error("base form wrong");

  property p_wrap;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && ok && circ && UPD_SEL != UPD_INC0 && UPD_SEL != UPD_INC1
     && cur <= s_q.modulo_range_reg && !LOAD_VALID
     && s_q.modulo_range_reg != 16'h0000)
      |=> (s_q.ptr[$past(PTR_SEL)] <= $past(s_q.modulo_range_reg));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap escaped range");

  property p_group_b_addr;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && ok && MODE == MODE_GROUP_B && PTR_SEL != CIRC_REG_IDX)
      |=> (ADDR == $past(cur));
  endproperty
  a_group_b_addr: assert property (p_group_b_addr)
    else $error("group b address not pointer");

  // a refused request must leave every pointer where it was
  property p_refused_hold;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && !ok && !LOAD_VALID)
      |=> (ADDR_ERROR && !ADDR_VALID && s_q.ptr == $past(s_q.ptr));
  endproperty
  a_refused_hold: assert property (p_refused_hold)
    else $error("refused request changed state");

  property p_c_circ_addr;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && ok && MODE == MODE_GROUP_C && CIRC_SEL
     && UPD_SEL != UPD_BASE)
      |=> (ADDR == $past(s_q.circular_offset_reg) + $past(cur));
  endproperty
  a_c_circ_addr: assert property (p_c_circ_addr)
    else $error("group c circular address wrong");

  property p_inc1_step;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (REQ_VALID && ok && !circ && MODE != MODE_DIRECT
     && UPD_SEL == UPD_INC1 && !LOAD_VALID)
      |=> (s_q.ptr[$past(PTR_SEL)]
           == $past(cur) + $past(s_q.increment_reg_1));
  endproperty
  a_inc1_step: assert property (p_inc1_step)
    else $error("increment update wrong");

  // a request in the same cycle would own the pointer, so leave it out
  property p_load_ptr;
    @(posedge REF_CLK) disable iff (SYS_RST)
    (LOAD_VALID && LOAD_SEL == {1'b0, CIRC_REG_IDX} && !REQ_VALID)
      |=> (CIRCULAR_POINTER_REG == $past(LOAD_DATA));
  endproperty
  a_load_ptr: assert property (p_load_ptr)
    else $error("pointer load lost");

  c_direct: cover property (@(posedge REF_CLK)
    REQ_VALID && MODE == MODE_DIRECT);
  c_circ: cover property (@(posedge REF_CLK)
    REQ_VALID && ok && circ && s_q.modulo_range_reg != 16'h0000);
  c_base: cover property (@(posedge REF_CLK)
    REQ_VALID && ok && UPD_SEL == UPD_BASE);
  c_err: cover property (@(posedge REF_CLK) ADDR_ERROR);
  c_wrap: cover property (@(posedge REF_CLK)
    REQ_VALID && ok && circ && UPD_SEL == UPD_M1
    && s_q.modulo_range_reg != 16'h0000);
endmodule : agu_core
`default_nettype wire

// ==== tb/agu_mem_model.sv ====
// agu_mem_model: data memory side of the address unit
// assumes ADDR means something only in a cycle with ADDR_VALID high
`default_nettype none
module agu_mem_model
  import agu_pkg::*;
(
  // memory side of the unit
  input wire logic clk,
  input wire logic acc_v,
  input wire logic [AW-1:0] acc_addr,
  // observation
  output logic [15:0] hits,
  output logic [AW-1:0] last
);
  timeunit 1ns;
  timeprecision 1ps;
  initial hits = 16'h0000;
  initial last = 16'h0000;
  // a held valid would count twice, so a stretched pulse shows up
  always @(posedge clk) begin
    if (acc_v === 1'b1) begin
      hits <= hits + 16'h0001;
      last <= acc_addr;
    end
  end
endmodule : agu_mem_model
`default_nettype wire

// ==== tb/test_dsp_address_generation_unit.sv ====
// test_dsp_address_generation_unit: self-checking bench for agu_core
// assumes agu_pkg, the rtl files and agu_mem_model are compiled first
`default_nettype none
module test_dsp_address_generation_unit
  import agu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  typedef struct packed {
    logic [1:0] m; logic [1:0] o; logic [2:0] p; logic [3:0] u;
    logic c; logic [6:0] d; logic e; logic [15:0] x;
  } row_t;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_v = 1'b0;
  agu_mode_t mode = MODE_DIRECT;
  agu_op_t op = OP_SINGLE;
  logic [2:0] ptr = 3'h0;
  agu_upd_t upd = UPD_Z;
  logic circ = 1'b0;
  logic [15:0] imm = 16'h0000;
  logic [6:0] disp = 7'h00;
  logic ld_v = 1'b0;
  logic [3:0] ld_sel = 4'h0;
  logic [15:0] ld_dat = 16'h0000;
  logic a_v, a_err;
  logic [15:0] addr, x7, hits, last;
  int err_total = 0;
  int tests_run = 0;
  logic [3:0] lsel [9] = '{4'h0, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'ha,
    4'hb, 4'hc};
  logic [15:0] lval [9] = '{16'h0010, 16'h0100, 16'h0200, 16'h0050,
    16'h0005, 16'hfff0, 16'h1000, 16'h0000, 16'h0000};
  // mode, op, pointer, update, circular, disp, refused, address
  row_t rows [31] = '{
    '{2'h0, 2'h0, 3'h0, 4'h3, 1'b0, 7'h00, 1'b0, 16'hbeef},
    '{2'h1, 2'h0, 3'h0, 4'h2, 1'b0, 7'h00, 1'b0, 16'h0010},
    '{2'h1, 2'h0, 3'h0, 4'h7, 1'b0, 7'h00, 1'b0, 16'h0011},
    '{2'h1, 2'h1, 3'h0, 4'h4, 1'b0, 7'h00, 1'b0, 16'h0016},
    '{2'h1, 2'h2, 3'h0, 4'h3, 1'b0, 7'h00, 1'b0, 16'h0015},
    '{2'h1, 2'h0, 3'h0, 4'h3, 1'b0, 7'h00, 1'b0, 16'h0015},
    '{2'h2, 2'h0, 3'h4, 4'h0, 1'b0, 7'h00, 1'b0, 16'h0100},
    '{2'h2, 2'h0, 3'h4, 4'h6, 1'b0, 7'h00, 1'b0, 16'h0103},
    '{2'h2, 2'h0, 3'h4, 4'h8, 1'b0, 7'h00, 1'b0, 16'h0100},
    '{2'h2, 2'h0, 3'h4, 4'h1, 1'b0, 7'h00, 1'b0, 16'h00f0},
    '{2'h2, 2'h0, 3'h4, 4'h5, 1'b0, 7'h00, 1'b0, 16'h00f2},
    '{2'h2, 2'h0, 3'h5, 4'h4, 1'b0, 7'h00, 1'b0, 16'h0200},
    '{2'h2, 2'h0, 3'h5, 4'h3, 1'b0, 7'h00, 1'b0, 16'h01ff},
    '{2'h2, 2'h0, 3'h7, 4'h2, 1'b1, 7'h00, 1'b0, 16'h0050},
    '{2'h3, 2'h0, 3'h0, 4'h9, 1'b0, 7'h7f, 1'b0, 16'h0fff},
    '{2'h3, 2'h0, 3'h0, 4'h9, 1'b0, 7'h3f, 1'b0, 16'h103f},
    '{2'h3, 2'h0, 3'h4, 4'h6, 1'b0, 7'h00, 1'b0, 16'h00f0},
    '{2'h3, 2'h0, 3'h4, 4'h7, 1'b0, 7'h00, 1'b0, 16'h00ed},
    '{2'h3, 2'h0, 3'h4, 4'h8, 1'b0, 7'h00, 1'b0, 16'h00f2},
    '{2'h3, 2'h0, 3'h4, 4'h3, 1'b0, 7'h00, 1'b0, 16'h00e2},
    '{2'h1, 2'h0, 3'h4, 4'h3, 1'b0, 7'h00, 1'b1, 16'h0000},
    '{2'h1, 2'h0, 3'h0, 4'h3, 1'b1, 7'h00, 1'b1, 16'h0000},
    '{2'h2, 2'h0, 3'h3, 4'h3, 1'b0, 7'h00, 1'b1, 16'h0000},
    '{2'h2, 2'h0, 3'h5, 4'h3, 1'b1, 7'h00, 1'b1, 16'h0000},
    '{2'h2, 2'h0, 3'h7, 4'h3, 1'b0, 7'h00, 1'b1, 16'h0000},
    '{2'h2, 2'h0, 3'h4, 4'h7, 1'b0, 7'h00, 1'b1, 16'h0000},
    '{2'h3, 2'h0, 3'h0, 4'h0, 1'b0, 7'h00, 1'b1, 16'h0000},
    '{2'h0, 2'h1, 3'h0, 4'h3, 1'b0, 7'h00, 1'b1, 16'h0000},
    '{2'h3, 2'h1, 3'h0, 4'h3, 1'b0, 7'h00, 1'b1, 16'h0000},
    '{2'h1, 2'h0, 3'h0, 4'h3, 1'b0, 7'h00, 1'b0, 16'h0015},
    '{2'h3, 2'h0, 3'h7, 4'h3, 1'b0, 7'h00, 1'b0, 16'h0051}
  };
  // ==========================================================
  // design and memory side
  agu_core dut_u (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .REQ_VALID(req_v),
    .MODE(mode), .OP_KIND(op), .PTR_SEL(ptr), .UPD_SEL(upd),
    .CIRC_SEL(circ), .IMMEDIATE_ADDRESS(imm), .SHORT_DISPLACEMENT(disp),
    .LOAD_VALID(ld_v), .LOAD_SEL(ld_sel), .LOAD_DATA(ld_dat),
    .ADDR_VALID(a_v), .ADDR(addr), .ADDR_ERROR(a_err),
    .CIRCULAR_POINTER_REG(x7));
  agu_mem_model mem_u (.clk(ref_clk), .acc_v(a_v), .acc_addr(addr),
    .hits(hits), .last(last));
  always #5 ref_clk = ~ref_clk;
  // ==========================================================
  // tasks
  task automatic chk_addr(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_addr
  task automatic chk_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag
  // a gap cycle after each load keeps one assignment per time step
  task automatic load(input logic [3:0] s, input logic [15:0] v);
    ld_v = 1'b1;
    ld_sel = s;
    ld_dat = v;
    @(negedge ref_clk);
    ld_v = 1'b0;
    @(negedge ref_clk);
  endtask : load
  task automatic req(input row_t r);
    req_v = 1'b1;
    mode = agu_mode_t'(r.m);
    op = agu_op_t'(r.o);
    ptr = r.p;
    upd = agu_upd_t'(r.u);
    circ = r.c;
    imm = r.x;
    disp = r.d;
    @(negedge ref_clk);
    // the answer stands only in the cycle after the taking edge
    req_v = 1'b0;
    ld_v = 1'b0;
    chk_flag(a_err, r.e);
    chk_flag(a_v, !r.e);
    if (!r.e) chk_addr(addr, r.x);
    @(negedge ref_clk);
  endtask : req
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // sequence
  initial begin
    #50000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk_flag(a_v, 1'b0);
    chk_addr(x7, 16'h0000);
    for (int i = 0; i < 9; i++) load(lsel[i], lval[i]);
    chk_addr(x7, 16'h0050);
    for (int i = 0; i < 31; i++) req(rows[i]);
    load(4'hb, 16'h2000);
    load(4'hc, 16'h0003);
    load(4'h7, 16'h0003);
    req('{2'h2, 2'h0, 3'h7, 4'h2, 1'b1, 7'h00, 1'b0, 16'h2003});
    chk_addr(x7, 16'h0000);
    req('{2'h3, 2'h0, 3'h7, 4'h4, 1'b1, 7'h00, 1'b0, 16'h2000});
    chk_addr(x7, 16'h0003);
    chk_addr(hits, 16'h0018);
    chk_addr(last, 16'h2000);
    // second reset in mid-run must clear the pointers again
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk_addr(x7, 16'h0000);
    chk_flag(a_v, 1'b0);
    // load and request on the first edge: the request's update wins
    ld_v = 1'b1;
    ld_sel = 4'h7;
    ld_dat = 16'h0040;
    req('{2'h2, 2'h0, 3'h7, 4'h2, 1'b1, 7'h00, 1'b0, 16'h0000});
    chk_addr(x7, 16'h0001);
    print_verdict();
  end
endmodule : test_dsp_address_generation_unit
`default_nettype wire
